/* include/tcs_pkg.sv */
// shared constants, state type and crc helper for the ticket card logic
package tcs_pkg;

  // link framing
  localparam int          RX_MAX_BYTES   = 18;
  localparam int          RESP_MAX_BYTES = 16;
  localparam logic [3:0]  DATA_BITS      = 4'h8;
  localparam logic [3:0]  SHORT_BITS     = 4'h7;
  localparam logic        START_BIT_VAL  = 1'b1;

  // command codes
  localparam logic [6:0]  CMD_REQ_IDLE   = 7'h26;
  localparam logic [6:0]  CMD_WAKE_ALL   = 7'h52;
  localparam logic [7:0]  CMD_SEL_CL1    = 8'h93;
  localparam logic [7:0]  CMD_SEL_CL2    = 8'h95;
  localparam logic [7:0]  NVB_SELECT     = 8'h70;
  localparam logic [7:0]  NVB_AC_MIN     = 8'h20;
  localparam logic [7:0]  NVB_AC_MAX     = 8'h67;
  localparam logic [7:0]  CMD_READ       = 8'h30;
  localparam logic [7:0]  CMD_WRITE      = 8'hA2;
  localparam logic [7:0]  CMD_HALT       = 8'h50;

  // frame lengths in bytes, crc included except in the anticollision frame
  localparam logic [4:0]  LEN_AC         = 5'h02;
  localparam logic [4:0]  LEN_SELECT     = 5'h09;
  localparam logic [4:0]  LEN_READ       = 5'h04;
  localparam logic [4:0]  LEN_HALT       = 5'h04;
  localparam logic [4:0]  LEN_WRITE      = 5'h08;

  // answers
  localparam logic [7:0]  ATQA_LO        = 8'h44;
  localparam logic [7:0]  ATQA_HI        = 8'h00;
  localparam logic [7:0]  SAK_CL1        = 8'h04;
  localparam logic [7:0]  SAK_CL2        = 8'h00;
  localparam logic [7:0]  WRITE_ACK      = 8'h0A;
  localparam logic [7:0]  CASCADE_TAG    = 8'h88;

  // memory map: 16 pages of 4 bytes, 512 bits
  localparam int          MEM_PAGES      = 16;
  localparam logic [3:0]  PAGE_UID0      = 4'h0;
  localparam logic [3:0]  PAGE_UID1      = 4'h1;
  localparam logic [3:0]  PAGE_LOCK      = 4'h2;
  localparam logic [3:0]  PAGE_OTP       = 4'h3;
  localparam logic [7:0]  INTERNAL_BYTE  = 8'h00;

  // crc over the link, reflected form, residue zero over data plus crc
  localparam logic [15:0] CRC_INIT       = 16'h6363;
  localparam logic [15:0] CRC_POLY       = 16'h8408;

  typedef enum logic [2:0] {
    IDLE_WAIT_STATE               = 3'h0,
    UID_FIRST_PART_RESOLVE_STATE  = 3'h1,
    UID_SECOND_PART_RESOLVE_STATE = 3'h3,
    ACTIVE_STATE                  = 3'h2,
    HALT_WAIT_STATE               = 3'h6
  } tcs_state_e;

  function automatic logic [15:0] tcs_crc_byte(input logic [15:0] crc,
                                               input logic [7:0]  d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

/* src/tcs_link_rx.sv */
// link-clock frame receiver: start bit, odd parity, bit count and crc checks
`timescale 1ns/1ps
`default_nettype none

module tcs_link_rx
  import tcs_pkg::*;
#(
  parameter int MAXB = RX_MAX_BYTES
) (
  // link side
  input  wire logic                link_clk,
  input  wire logic                rst_n,
  input  wire logic                link_bit_en,
  input  wire logic                link_bit,
  input  wire logic                link_end,
  // frame result, stable after rx_toggle flips
  output logic [MAXB*8-1:0]        rx_bytes,
  output logic [4:0]               rx_count,
  output logic                     rx_short,
  output logic [6:0]               rx_short_data,
  output logic                     rx_err,
  output logic                     rx_crc_ok,
  output logic                     rx_toggle
);

  logic        started_q;
  logic [3:0]  bitpos_q;
  logic [7:0]  shift_q;
  logic        par_q;
  logic [15:0] crc_q;
  logic [4:0]  cnt_q;
  logic        err_q;

  ////////////////////////////////////////////////////////////////////////////
  // bit assembly
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      started_q <= 1'b0;
      bitpos_q  <= 4'h0;
      shift_q   <= 8'h00;
      par_q     <= 1'b0;
      crc_q     <= CRC_INIT;
      cnt_q     <= 5'h00;
      err_q     <= 1'b0;
      rx_bytes  <= '0;
    end else if (link_end) begin
      started_q <= 1'b0;
      bitpos_q  <= 4'h0;
      shift_q   <= 8'h00;
      par_q     <= 1'b0;
      crc_q     <= CRC_INIT;
      cnt_q     <= 5'h00;
      err_q     <= 1'b0;
    end else if (link_bit_en) begin
      if (!started_q) begin
        started_q <= 1'b1;
        if (link_bit != START_BIT_VAL)
          err_q <= 1'b1;
      end else if (bitpos_q < DATA_BITS) begin
        shift_q[bitpos_q[2:0]] <= link_bit;
        par_q    <= par_q ^ link_bit;
        bitpos_q <= bitpos_q + 4'h1;
      end else begin
        if ((par_q ^ link_bit) != 1'b1)
          err_q <= 1'b1;
        if (cnt_q < 5'(MAXB)) begin
          rx_bytes[cnt_q*8 +: 8] <= shift_q;
          cnt_q <= cnt_q + 5'h01;
        end else begin
          err_q <= 1'b1;
        end
        crc_q    <= tcs_crc_byte(crc_q, shift_q);
        bitpos_q <= 4'h0;
        par_q    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame close; flags held until the next frame ends
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_count      <= 5'h00;
      rx_short      <= 1'b0;
      rx_short_data <= 7'h00;
      rx_err        <= 1'b0;
      rx_crc_ok     <= 1'b0;
      rx_toggle     <= 1'b0;
    end else if (link_end) begin
      rx_count      <= cnt_q;
      rx_short      <= (cnt_q == 5'h00) && (bitpos_q == SHORT_BITS);
      rx_short_data <= shift_q[6:0];
      // bit count: whole bytes only, or one short frame
      rx_err        <= err_q || !started_q ||
                       ((bitpos_q != 4'h0) &&
                        !((cnt_q == 5'h00) && (bitpos_q == SHORT_BITS))) ||
                       ((cnt_q == 5'h00) && (bitpos_q == 4'h0));
      rx_crc_ok     <= (crc_q == 16'h0000);
      rx_toggle     <= ~rx_toggle;
    end
  end

endmodule

`default_nettype wire

/* src/tcs_card_fsm.sv */
// ticket card command interpreter: wait, uid resolution, active, memory
`timescale 1ns/1ps
`default_nettype none

// Function
// - after power-on reset the machine sits in idle with no command
// - idle is left only through the request or wake-up command
// - in idle any other frame is an error: stay idle, stay silent
// - after a proper halt, halt is the waiting state; only wake-up exits
// - first resolution answers level-1 anticollision and select for 3 bytes
// - level-1 select moves the card to the second resolution state
// - read of page 0 in first resolution jumps straight to active
// - unexpected command or bad data returns to idle, or halt if halted
// - second resolution answers level-2 anticollision for the last 4 bytes
// - reader ends second resolution with level-2 select; card leaves then
// - read of page 0 in second resolution also jumps to active
// - level-2 select answered with one select-acknowledge byte
// - once selected the card keeps talking; others stay silent
// - reader starts every exchange; card only answers
// - seven-byte identifier resolved over two cascade levels
// - identifier fixed at manufacture, no command can change it
// - memory is 512 bits: 16 pages of 4 bytes, page addressed
// - 80 bits maker data, 16 lock bits, 32 otp, 384 user bits
// - 32-bit write-once area usable as one-time counter
// - per-page lock bits; a locked page cannot be changed after the next request or wake-up
// - frames checked by 16-bit crc, parity, start bit and bit count
// - active runs 16-byte read or 4-byte write; halt exits; else waits
// - in halt everything but wake-up is ignored; card stays halted
// - lock and otp writes are or-ed in; set bits never clear
// - one start bit, odd parity per byte, lsb of lowest byte first
module tcs_card_fsm
  import tcs_pkg::*;
#(
  // identifier, byte 0 in the low bits; value is arbitrary
  parameter logic [55:0] UID_VALUE = 56'h6655443322115A,
  parameter int          MAXB      = RX_MAX_BYTES
) (
  // system clock and power-on reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // link from the reader
  input  wire logic       link_clk,
  input  wire logic       link_bit_en,
  input  wire logic       link_bit,
  input  wire logic       link_end,
  // answer bytes
  output logic            tx_valid,
  output logic [7:0]      tx_byte,
  output logic            tx_last,
  // status
  output tcs_state_e      card_state_q,
  output logic            card_halted_q
);

  ////////////////////////////////////////////////////////////////////////////
  // identifier and cascade bytes, constant so never writable
  localparam logic [7:0] SN0  = UID_VALUE[7:0];
  localparam logic [7:0] SN1  = UID_VALUE[15:8];
  localparam logic [7:0] SN2  = UID_VALUE[23:16];
  localparam logic [7:0] SN3  = UID_VALUE[31:24];
  localparam logic [7:0] SN4  = UID_VALUE[39:32];
  localparam logic [7:0] SN5  = UID_VALUE[47:40];
  localparam logic [7:0] SN6  = UID_VALUE[55:48];
  localparam logic [7:0] BCC0 = CASCADE_TAG ^ SN0 ^ SN1 ^ SN2;
  localparam logic [7:0] BCC1 = SN3 ^ SN4 ^ SN5 ^ SN6;
  localparam logic [39:0] CASC1 = {BCC0, SN2, SN1, SN0, CASCADE_TAG};
  localparam logic [39:0] CASC2 = {BCC1, SN6, SN5, SN4, SN3};

  typedef enum logic [2:0] {
    RESP_NONE, RESP_ATQA, RESP_UID, RESP_SAK1, RESP_SAK2, RESP_READ, RESP_ACK
  } tcs_resp_e;

  ////////////////////////////////////////////////////////////////////////////
  // link domain receiver
  logic [MAXB*8-1:0] rx_bytes;
  logic [4:0]        rx_count;
  logic              rx_short;
  logic [6:0]        rx_short_data;
  logic              rx_err;
  logic              rx_crc_ok;
  logic              rx_toggle;

  tcs_link_rx #(.MAXB(MAXB)) u_rx (
    .link_clk      (link_clk),
    .rst_n         (rst_n),
    .link_bit_en   (link_bit_en),
    .link_bit      (link_bit),
    .link_end      (link_end),
    .rx_bytes      (rx_bytes),
    .rx_count      (rx_count),
    .rx_short      (rx_short),
    .rx_short_data (rx_short_data),
    .rx_err        (rx_err),
    .rx_crc_ok     (rx_crc_ok),
    .rx_toggle     (rx_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame event crossing; flags are stable until the next frame ends, frame bytes only until its first byte lands
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic frame_new;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= rx_toggle;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign frame_new = tog_s2_q ^ tog_s3_q;

  function automatic logic [7:0] rx_b(input logic [MAXB*8-1:0] v,
                                      input int i);
    return v[i*8 +: 8];
  endfunction

  function automatic logic page_locked(input logic [15:0] lk,
                                       input logic [3:0]  pg);
    return (pg >= PAGE_OTP) && lk[pg];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // memory and lock snapshot
  logic [31:0] mem_q [MEM_PAGES];
  logic [15:0] lock_act_q;
  logic        tx_busy_q;

  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [3:0]  addr;
  logic        is_req;
  logic        is_wake;
  logic        is_ac1;
  logic        is_ac2;
  logic        is_sel1;
  logic        is_sel2;
  logic        is_read;
  logic        is_read0;
  logic        is_halt;
  logic        is_write;
  logic        wr_ok;
  logic [31:0] wr_data;
  logic [15:0] lock_cur;
  logic [15:0] lock_frz;

  assign b0       = rx_b(rx_bytes, 0);
  assign b1       = rx_b(rx_bytes, 1);
  assign addr     = b1[3:0];
  assign wr_data  = rx_bytes[47:16];
  assign lock_cur = mem_q[PAGE_LOCK][31:16];
  // block-lock bits freeze groups of page-lock bits
  assign lock_frz = {{6{lock_cur[2]}}, {6{lock_cur[1]}}, lock_cur[0], 3'h0};

  assign is_req   = rx_short && (rx_short_data == CMD_REQ_IDLE);
  assign is_wake  = rx_short && (rx_short_data == CMD_WAKE_ALL);
  assign is_ac1   = !rx_short && (rx_count == LEN_AC) &&
                    (b0 == CMD_SEL_CL1) && (b1 >= NVB_AC_MIN) &&
                    (b1 <= NVB_AC_MAX);
  assign is_ac2   = !rx_short && (rx_count == LEN_AC) &&
                    (b0 == CMD_SEL_CL2) && (b1 >= NVB_AC_MIN) &&
                    (b1 <= NVB_AC_MAX);
  assign is_sel1  = rx_crc_ok && (rx_count == LEN_SELECT) &&
                    (b0 == CMD_SEL_CL1) && (b1 == NVB_SELECT) &&
                    (rx_bytes[55:16] == CASC1);
  assign is_sel2  = rx_crc_ok && (rx_count == LEN_SELECT) &&
                    (b0 == CMD_SEL_CL2) && (b1 == NVB_SELECT) &&
                    (rx_bytes[55:16] == CASC2);
  assign is_read  = rx_crc_ok && (rx_count == LEN_READ) &&
                    (b0 == CMD_READ) && (b1 < 8'(MEM_PAGES));
  assign is_read0 = is_read && (b1 == 8'h00);
  assign is_halt  = rx_crc_ok && (rx_count == LEN_HALT) &&
                    (b0 == CMD_HALT) && (b1 == 8'h00);
  assign is_write = rx_crc_ok && (rx_count == LEN_WRITE) &&
                    (b0 == CMD_WRITE) && (b1 < 8'(MEM_PAGES));
  // identifier pages never written; locked pages refused
  assign wr_ok    = is_write && (addr > PAGE_UID1) &&
                    !page_locked(lock_act_q, addr);

  ////////////////////////////////////////////////////////////////////////////
  // state decision
  tcs_state_e state_d;
  tcs_state_e wait_state;
  tcs_resp_e  resp_kind;
  logic       halted_d;
  logic       do_write;
  logic       snap_lock;

  // waiting state depends on whether a halt was ever executed
  assign wait_state = card_halted_q ? HALT_WAIT_STATE : IDLE_WAIT_STATE;

  always_comb begin
    state_d   = card_state_q;
    halted_d  = card_halted_q;
    resp_kind = RESP_NONE;
    do_write  = 1'b0;
    snap_lock = 1'b0;
    // card never speaks unprompted; frames arriving mid-answer dropped
    if (frame_new && !tx_busy_q) begin
      case (card_state_q)
        IDLE_WAIT_STATE: begin
          if (!rx_err && (is_req || is_wake)) begin
            state_d   = UID_FIRST_PART_RESOLVE_STATE;
            resp_kind = RESP_ATQA;
            snap_lock = 1'b1;
          end
        end
        HALT_WAIT_STATE: begin
          if (!rx_err && is_wake) begin
            state_d   = UID_FIRST_PART_RESOLVE_STATE;
            resp_kind = RESP_ATQA;
            snap_lock = 1'b1;
          end
        end
        UID_FIRST_PART_RESOLVE_STATE: begin
          if (rx_err) begin
            state_d = wait_state;
          end else if (is_ac1) begin
            resp_kind = RESP_UID;
          end else if (is_sel1) begin
            state_d   = UID_SECOND_PART_RESOLVE_STATE;
            resp_kind = RESP_SAK1;
          end else if (is_read0) begin
            state_d   = ACTIVE_STATE;
            resp_kind = RESP_READ;
          end else begin
            state_d = wait_state;
          end
        end
        UID_SECOND_PART_RESOLVE_STATE: begin
          if (rx_err) begin
            state_d = wait_state;
          end else if (is_ac2) begin
            resp_kind = RESP_UID;
          end else if (is_sel2) begin
            state_d   = ACTIVE_STATE;
            resp_kind = RESP_SAK2;
          end else if (is_read0) begin
            state_d   = ACTIVE_STATE;
            resp_kind = RESP_READ;
          end else begin
            state_d = wait_state;
          end
        end
        ACTIVE_STATE: begin
          if (!rx_err && is_read) begin
            resp_kind = RESP_READ;
          end else if (!rx_err && is_write) begin
            do_write  = wr_ok;
            resp_kind = wr_ok ? RESP_ACK : RESP_NONE;
          end else if (!rx_err && is_halt) begin
            state_d  = HALT_WAIT_STATE;
            halted_d = 1'b1;
          end else begin
            state_d = wait_state;
          end
        end
        default: state_d = IDLE_WAIT_STATE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_state_q  <= IDLE_WAIT_STATE;
      card_halted_q <= 1'b0;
    end else begin
      card_state_q  <= state_d;
      card_halted_q <= halted_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory: 16 pages of 4 bytes
  // reset models the factory image; a real part keeps contents across power
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < MEM_PAGES; p++) begin
        mem_q[p] <= 32'h00000000;
      end
      mem_q[PAGE_UID0] <= {BCC0, SN2, SN1, SN0};
      mem_q[PAGE_UID1] <= {SN6, SN5, SN4, SN3};
      mem_q[PAGE_LOCK] <= {16'h0000, INTERNAL_BYTE, BCC1};
    end else if (do_write) begin
      if (addr == PAGE_LOCK) begin
        // bytes 0 and 1 untouched; lock bits only ever accumulate
        mem_q[PAGE_LOCK][31:16] <= lock_cur |
                                   (wr_data[31:16] & ~lock_frz);
      end else if (addr == PAGE_OTP) begin
        mem_q[PAGE_OTP] <= mem_q[PAGE_OTP] | wr_data;
      end else begin
        mem_q[addr] <= wr_data;
      end
    end
  end

  // new locking only takes effect at the next request or wake-up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_act_q <= 16'h0000;
    end else if (snap_lock) begin
      lock_act_q <= lock_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer builder
  logic [7:0] resp_d [RESP_MAX_BYTES];
  logic [4:0] len_d;
  logic       crc_en_d;
  logic [2:0] known;

  // whole bytes already known to the reader from the count byte
  assign known = b1[6:4] - 3'h2;

  always_comb begin
    for (int i = 0; i < RESP_MAX_BYTES; i++) begin
      resp_d[i] = 8'h00;
    end
    len_d    = 5'h00;
    crc_en_d = 1'b0;
    case (resp_kind)
      RESP_ATQA: begin
        resp_d[0] = ATQA_LO;
        resp_d[1] = ATQA_HI;
        len_d     = 5'h02;
      end
      RESP_UID: begin
        for (int i = 0; i < 5; i++) begin
          if (i + int'(known) < 5)
            resp_d[i] = (b0 == CMD_SEL_CL1) ?
                        CASC1[(i + int'(known))*8 +: 8] :
                        CASC2[(i + int'(known))*8 +: 8];
        end
        len_d = 5'h05 - {2'h0, known};
      end
      RESP_SAK1: begin
        resp_d[0] = SAK_CL1;
        len_d     = 5'h01;
        crc_en_d  = 1'b1;
      end
      RESP_SAK2: begin
        resp_d[0] = SAK_CL2;
        len_d     = 5'h01;
        crc_en_d  = 1'b1;
      end
      RESP_READ: begin
        // four pages, address wraps at the top of memory
        for (int i = 0; i < RESP_MAX_BYTES; i++) begin
          resp_d[i] = mem_q[addr + 4'(i / 4)][(i % 4)*8 +: 8];
        end
        len_d    = 5'h10;
        crc_en_d = 1'b1;
      end
      RESP_ACK: begin
        resp_d[0] = WRITE_ACK;
        len_d     = 5'h01;
      end
      default: len_d = 5'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer serializer: one byte per cycle, crc low byte then high byte
  logic [7:0]  resp_q [RESP_MAX_BYTES];
  logic [4:0]  len_q;
  logic [4:0]  idx_q;
  logic        crc_en_q;
  logic [15:0] txcrc_q;
  logic [4:0]  total;

  assign total = len_q + (crc_en_q ? 5'h02 : 5'h00);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RESP_MAX_BYTES; i++) begin
        resp_q[i] <= 8'h00;
      end
      len_q     <= 5'h00;
      idx_q     <= 5'h00;
      crc_en_q  <= 1'b0;
      txcrc_q   <= CRC_INIT;
      tx_busy_q <= 1'b0;
      tx_valid  <= 1'b0;
      tx_byte   <= 8'h00;
      tx_last   <= 1'b0;
    end else if (!tx_busy_q) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      if (resp_kind != RESP_NONE) begin
        for (int i = 0; i < RESP_MAX_BYTES; i++) begin
          resp_q[i] <= resp_d[i];
        end
        len_q     <= len_d;
        crc_en_q  <= crc_en_d;
        idx_q     <= 5'h00;
        txcrc_q   <= CRC_INIT;
        tx_busy_q <= 1'b1;
      end
    end else begin
      tx_valid <= 1'b1;
      tx_last  <= (idx_q == total - 5'h01);
      if (idx_q < len_q) begin
        tx_byte <= resp_q[idx_q[3:0]];
        txcrc_q <= tcs_crc_byte(txcrc_q, resp_q[idx_q[3:0]]);
      end else if (idx_q == len_q) begin
        tx_byte <= txcrc_q[7:0];
      end else begin
        tx_byte <= txcrc_q[15:8];
      end
      idx_q <= idx_q + 5'h01;
      if (idx_q == total - 5'h01)
        tx_busy_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* verif/tcs_card_fsm_properties.sv */
// port assertions for the card command interpreter
`timescale 1ns/1ps
`default_nettype none

module tcs_card_fsm_properties
  import tcs_pkg::*;
(
  // watched design ports
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_last,
  input var tcs_state_e  card_state_q,
  input wire logic       card_halted_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence enter1_s;
    $rose(card_state_q == UID_FIRST_PART_RESOLVE_STATE);
  endsequence
  sequence atqa_s;
    tx_valid && tx_byte == ATQA_LO ##1 tx_valid && tx_last && tx_byte == ATQA_HI;
  endsequence

  halt_sticky_a: assert property (card_halted_q |=> card_halted_q)
    else $error("halt flag cleared");
  halted_wait_a: assert property (card_halted_q |-> card_state_q != IDLE_WAIT_STATE)
    else $error("halted card fell to idle");
  idle_exit_a: assert property ($past(card_state_q) == IDLE_WAIT_STATE &&
    card_state_q != IDLE_WAIT_STATE |-> card_state_q == UID_FIRST_PART_RESOLVE_STATE)
    else $error("bad exit from idle");
  halt_exit_a: assert property ($past(card_state_q) == HALT_WAIT_STATE &&
    card_state_q != HALT_WAIT_STATE |-> card_state_q == UID_FIRST_PART_RESOLVE_STATE)
    else $error("bad exit from halt");
  wait_silent_a: assert property (card_state_q inside {IDLE_WAIT_STATE,
    HALT_WAIT_STATE} |-> !tx_valid) else $error("answer while waiting");
  atqa_answer_a: assert property (enter1_s |-> ##[1:2] atqa_s)
    else $error("no request answer");
  burst_a: assert property (tx_valid && !tx_last |=> tx_valid)
    else $error("answer broken off");
  last_valid_a: assert property (tx_last |-> tx_valid)
    else $error("last without valid");
  active_entry_a: assert property (card_state_q == ACTIVE_STATE &&
    $past(card_state_q) != ACTIVE_STATE |-> $past(card_state_q) inside
    {UID_FIRST_PART_RESOLVE_STATE, UID_SECOND_PART_RESOLVE_STATE})
    else $error("active entered from wrong state");
endmodule

bind tcs_card_fsm tcs_card_fsm_properties i_props (.sys_clk(sys_clk),
  .rst_n(rst_n), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
  .card_state_q(card_state_q), .card_halted_q(card_halted_q));

`default_nettype wire

/* verif/tcs_reader_model.sv */
// reader model: gated link clock and framed bits toward the card
`timescale 1ns/1ps
`default_nettype none

module tcs_reader_model (
  // link toward the card
  output logic link_clk,
  output logic link_bit_en,
  output logic link_bit,
  output logic link_end
);
  // data line toggles when unused so a stale value never looks valid
  task automatic tick(input logic b, input logic en, input logic e);
    link_bit    = en ? b : ~link_bit;
    link_bit_en = en;
    link_end    = e;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
  endtask

  // fl: bit0 add crc, bit1 seven-bit short frame, bit2 corrupt parity
  task automatic send(input logic [7:0] q[$], input logic [2:0] fl);
    logic [15:0] c;
    c = 16'h6363;
    if (fl[0]) begin
      foreach (q[i]) begin
        c = c ^ {8'h00, q[i]};
        repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
    end
    repeat (2) tick(1'b0, 1'b0, 1'b0);
    tick(1'b1, 1'b1, 1'b0);
    foreach (q[i]) begin
      for (int k = 0; k < (fl[1] ? 7 : 8); k++) tick(q[i][k], 1'b1, 1'b0);
      if (!fl[1]) tick(~^q[i] ^ fl[2], 1'b1, 1'b0);
    end
    tick(1'b0, 1'b0, 1'b1);
    repeat (2) tick(1'b0, 1'b0, 1'b0);
  endtask

  initial begin
    link_clk = 1'b0;
    link_bit = 1'b0;
    repeat (6) tick(1'b0, 1'b0, 1'b0);
  end
endmodule

`default_nettype wire

/* verif/tb_tcs_card_fsm.sv */
// self-checking bench for the card command interpreter
`timescale 1ns/1ps
`default_nettype none

module tb_tcs_card_fsm
  import tcs_pkg::*;
;
  logic       sys_clk, rst_n, link_clk, link_bit_en, link_bit, link_end;
  logic       tx_valid, tx_last, card_halted_q;
  logic [7:0] tx_byte;
  tcs_state_e card_state_q;
  logic [7:0] rx_q[$], wd[$];
  logic [7:0] s1[$] = '{8'h93, 8'h70, 8'h88, 8'h5A, 8'h11, 8'h22, 8'hE1};
  logic [7:0] s2[$] = '{8'h95, 8'h70, 8'h33, 8'h44, 8'h55, 8'h66, 8'h44};
  int         num_errors, check_count, seed;

  tcs_card_fsm i_tcs_card_fsm (.sys_clk(sys_clk), .rst_n(rst_n),
    .link_clk(link_clk), .link_bit_en(link_bit_en), .link_bit(link_bit),
    .link_end(link_end), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_last(tx_last), .card_state_q(card_state_q),
    .card_halted_q(card_halted_q));
  tcs_reader_model i_tcs_reader_model (.link_clk(link_clk),
    .link_bit_en(link_bit_en), .link_bit(link_bit), .link_end(link_end));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (tx_valid === 1'b1) rx_q.push_back(tx_byte);

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // send one frame, wait bounded for n answer bytes, then check
  task automatic x(input logic [7:0] q[$], input logic [2:0] fl,
                   input tcs_state_e st, input int n);
    rx_q = {};
    i_tcs_reader_model.send(q, fl);
    for (int w = 0; w < 60 && rx_q.size() < n; w++) @(negedge sys_clk);
    if (rx_q.size() < n) num_errors++;
    if (rx_q.size() < n) report_and_stop();
    repeat (10) @(negedge sys_clk);
    check("state", card_state_q, st);
    check("count", rx_q.size(), n);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("reset", {card_halted_q, card_state_q}, {1'b0, IDLE_WAIT_STATE});
  endtask

  initial begin
    logic [31:0] r;
    seed = 77979;
    do_reset();
    repeat (3) begin
      r = $random(seed);
      x('{r[7:0], r[15:8]}, 3'h1, IDLE_WAIT_STATE, 0);
    end
    x('{8'h26}, 3'h2, UID_FIRST_PART_RESOLVE_STATE, 2);
    check("atqa", rx_q[0], ATQA_LO);
    x('{8'h93, 8'h20}, 3'h0, UID_FIRST_PART_RESOLVE_STATE, 5);
    check("cl1", rx_q[1], 8'h5A);
    x(s1, 3'h1, UID_SECOND_PART_RESOLVE_STATE, 3);
    x('{8'h95, 8'h20}, 3'h0, UID_SECOND_PART_RESOLVE_STATE, 5);
    check("cl2", rx_q[4], 8'h44);
    x(s2, 3'h1, ACTIVE_STATE, 3);
    check("sak", rx_q[0], SAK_CL2);
    r = $random(seed);
    wd = '{r[7:0], r[15:8], r[23:16], r[31:24]};
    x({8'hA2, 8'h05, wd}, 3'h1, ACTIVE_STATE, 1);
    check("ack", rx_q[0], WRITE_ACK);
    x('{8'h30, 8'h04}, 3'h1, ACTIVE_STATE, 18);
    foreach (wd[i]) check("rd", rx_q[4 + i], wd[i]);
    x({8'hA2, 8'h03, wd}, 3'h1, ACTIVE_STATE, 1);
    x('{8'hA2, 8'h03, 8'h0, 8'h0, 8'h0, 8'h0}, 3'h1, ACTIVE_STATE, 1);
    x('{8'h30, 8'h03}, 3'h1, ACTIVE_STATE, 18);
    foreach (wd[i]) check("otp", rx_q[i], wd[i]);
    x({8'hA2, 8'h00, wd}, 3'h1, ACTIVE_STATE, 0);
    x('{8'h30, 8'h00}, 3'h1, ACTIVE_STATE, 18);
    check("uid", rx_q[0], 8'h5A);
    x('{8'h50, 8'h00}, 3'h1, HALT_WAIT_STATE, 0);
    x('{8'h26}, 3'h2, HALT_WAIT_STATE, 0);
    x('{8'h52}, 3'h2, UID_FIRST_PART_RESOLVE_STATE, 2);
    x('{8'h30, 8'h00}, 3'h1, ACTIVE_STATE, 18);
    x('{8'h30, 8'h00}, 3'h5, HALT_WAIT_STATE, 0);
    x('{8'h52}, 3'h2, UID_FIRST_PART_RESOLVE_STATE, 2);
    x(s1, 3'h1, UID_SECOND_PART_RESOLVE_STATE, 3);
    x('{8'h30, 8'h00}, 3'h1, ACTIVE_STATE, 18);
    x('{8'h52}, 3'h2, HALT_WAIT_STATE, 0);
    do_reset();
    report_and_stop();
  end
endmodule

`default_nettype wire
